// ### common/jfa_pkg.sv
// Package for the flash access control block: register layout, modes, flash request types
package jfa_pkg;
  localparam int         CTRL_W         = 8;
  localparam int         WIN_W          = 10;
  localparam int         ADDR_W         = 16;
  localparam int         SCR_BIT        = 7;
  localparam int         WR_LO          = 4;
  localparam int         WR_HI          = 6;
  localparam int         RD_LO          = 0;
  localparam int         RD_HI          = 3;
  localparam int         DATA_LO        = 2;
  localparam int         DATA_HI        = 9;
  localparam int         FAIL_BIT       = 1;
  localparam int         BUSY_BIT       = 0;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [9:0] WIN_RESET      = 10'h000;
  localparam logic [15:0] PTR_RESET     = 16'h0000;
  localparam logic [7:0] ERASE_KEY      = 8'ha5;
  localparam logic [7:0] ERASED_BYTE    = 8'hff;
  localparam logic [6:0] SCRATCH_MAX    = 7'h7f;
  localparam logic [2:0] WR_STORE       = 3'h0;
  localparam logic [2:0] WR_PROGRAM     = 3'h1;
  localparam logic [2:0] WR_ERASE       = 3'h2;
  localparam logic [3:0] RD_PLAIN       = 4'h0;
  localparam logic [3:0] RD_BLOCK       = 4'h1;
  localparam logic [3:0] RD_SINGLE      = 4'h2;

  typedef enum logic [1:0] {
    JFA_OP_READ,
    JFA_OP_PROG,
    JFA_OP_PAGE_ERASE,
    JFA_OP_USER_ERASE
  } jfa_op_e;

  // Request toward the flash array
  typedef struct packed {
    logic              valid;
    jfa_op_e           op;
    logic              scratch;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } jfa_req_s;

  // Completion from the flash array
  typedef struct packed {
    logic       done;
    logic       fail;
    logic [7:0] data;
  } jfa_rsp_s;
endpackage

// ### core/jfa_ctrl.sv
// Flash access control: control register, data window and pointer for debug-port flash access
//
// Summary of operation
// - Scratch bit high routes flash accesses to the 128-byte scratchpad, else main flash.
// - Write mode 000: window write stores the byte only, no flash operation.
// - Write mode 001: window write programs byte at pointer; pointer increments on completion.
// - Write mode 010: window write erases the page holding pointer; pointer stays.
// - Erase happens only when the written byte equals 0xA5.
// - Erasing either lock byte erases all user flash except the reserved area.
// - Read mode 0000: window read returns content, no flash operation.
// - Read mode 0001: window read launches read at pointer when idle; block reads.
// - Read mode 0010: launch only when idle and earlier read data already fetched.
// - Control: scratch bit 7, write mode bits 6-4, read mode bits 3-0.
// - Pointer increments after each flash read or program, success or failure.
// - While busy, window reads and writes start no flash operation.
// - Window holds data in bits 9-2, fail at bit 1, busy at bit 0.
`timescale 1ns/1ps
`default_nettype none

module jfa_ctrl (
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic                      ctrl_wr,
  input  wire logic [jfa_pkg::CTRL_W-1:0] ctrl_wdata,
  output logic      [jfa_pkg::CTRL_W-1:0] ctrl_rdata,
  input  wire logic                      ptr_wr,
  input  wire logic [jfa_pkg::ADDR_W-1:0] ptr_wdata,
  output logic      [jfa_pkg::ADDR_W-1:0] ptr_rdata,
  input  wire logic                      win_wr,
  input  wire logic [7:0]                win_wdata,
  input  wire logic                      win_rd,
  output logic      [jfa_pkg::WIN_W-1:0]  win_rdata,
  input  wire logic [jfa_pkg::ADDR_W-1:0] lock_rd_addr,
  input  wire logic [jfa_pkg::ADDR_W-1:0] lock_wr_addr,
  output jfa_pkg::jfa_req_s              flash_req,
  input  wire jfa_pkg::jfa_rsp_s         flash_rsp
);
  import jfa_pkg::*;

  logic [CTRL_W-1:0] ctrl;
  logic [7:0]        data_byte;
  logic              fail;
  logic              busy;
  logic              fetched;
  logic [ADDR_W-1:0] ptr;
  logic              op_is_read;
  logic              op_moves_ptr;
  jfa_req_s          req;
  logic [ADDR_W-1:0] next_ptr;

  wire               scratch   = ctrl[SCR_BIT];
  wire [2:0]         wr_mode   = ctrl[WR_HI:WR_LO];
  wire [3:0]         rd_mode   = ctrl[RD_HI:RD_LO];

  // Mode decode
  wire               wr_prog   = (wr_mode == WR_PROGRAM);
  wire               wr_erase  = (wr_mode == WR_ERASE);
  wire               key_ok    = (win_wdata == ERASE_KEY);
  wire               rd_block  = (rd_mode == RD_BLOCK);
  wire               rd_single = (rd_mode == RD_SINGLE);

  // Either lock byte widens an erase to the whole user space
  function automatic logic is_lock_byte(input logic [ADDR_W-1:0] a,
                                        input logic [ADDR_W-1:0] rd_lock,
                                        input logic [ADDR_W-1:0] wr_lock);
    return (a == rd_lock) || (a == wr_lock);
  endfunction

  // Launch decode; nothing starts while busy
  wire               idle      = !busy;
  wire               go_prog   = win_wr && idle && wr_prog;
  wire               go_erase  = win_wr && idle && wr_erase && key_ok;
  wire               hits_lock = !scratch && is_lock_byte(ptr, lock_rd_addr, lock_wr_addr);
  wire               go_read   = win_rd && idle && (rd_block || (rd_single && fetched));
  wire               go_any    = go_prog || go_erase || go_read;
  wire               store_wr  = win_wr && idle;
  wire [6:0]         scr_addr  = ptr[6:0] & SCRATCH_MAX;

  // Completion is only taken while an operation is open
  wire               op_done   = busy && flash_rsp.done;
  wire               rd_done   = op_done && op_is_read;

  // Request contents
  jfa_req_s next_req;
  always_comb begin
    next_req         = '0;
    next_req.valid   = go_any;
    next_req.scratch = scratch;
    next_req.addr    = scratch ? {{(ADDR_W-7){1'b0}}, scr_addr} : ptr;
    next_req.data    = win_wdata;
    if (go_read) begin
      next_req.op = JFA_OP_READ;
    end else if (go_prog) begin
      next_req.op = JFA_OP_PROG;
    end else if (hits_lock) begin
      next_req.op = JFA_OP_USER_ERASE;
    end else begin
      next_req.op = JFA_OP_PAGE_ERASE;
    end
  end

  // Control register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl <= ctrl_wdata;
    end
  end

  // Flash request pulse
  always_ff @(posedge clk) begin
    if (!nrst) begin
      req <= '0;
    end else begin
      req <= next_req;
    end
  end

  // Busy from launch until the flash answers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy <= 1'b0;
    end else if (go_any) begin
      busy <= 1'b1;
    end else if (op_done) begin
      busy <= 1'b0;
    end
  end

  // Fail reflects the last completed operation
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fail <= 1'b0;
    end else if (op_done) begin
      fail <= flash_rsp.fail;
    end
  end

  // Kind of the open operation
  always_ff @(posedge clk) begin
    if (!nrst) begin
      op_is_read   <= 1'b0;
      op_moves_ptr <= 1'b0;
    end else if (go_any) begin
      op_is_read   <= go_read;
      op_moves_ptr <= go_read || go_prog;
    end
  end

  // Data byte; a launching read still shows the previous byte
  always_ff @(posedge clk) begin
    if (!nrst) begin
      data_byte <= WIN_RESET[DATA_HI:DATA_LO];
    end else if (store_wr) begin
      data_byte <= win_wdata;
    end else if (rd_done) begin
      data_byte <= flash_rsp.data;
    end
  end

  // Fetched: new read data clears it, a host read sets it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fetched <= 1'b1;
    end else if (rd_done) begin
      fetched <= 1'b0;
    end else if (win_rd) begin
      fetched <= 1'b1;
    end
  end

  // Pointer: advance when a read or program finishes, else host load while idle
  always_comb begin
    next_ptr = ptr;
    if (op_done && op_moves_ptr) begin
      next_ptr = ptr + 16'h0001;
    end else if (ptr_wr && idle) begin
      next_ptr = ptr_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ptr <= PTR_RESET;
    end else begin
      ptr <= next_ptr;
    end
  end

  // Registered read-back, one cycle behind the state
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_rdata <= CTRL_RESET;
    end else begin
      ctrl_rdata <= ctrl;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ptr_rdata <= PTR_RESET;
    end else begin
      ptr_rdata <= ptr;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      win_rdata <= WIN_RESET;
    end else begin
      win_rdata <= {data_byte, fail, busy};
    end
  end

  assign flash_req = req;

endmodule

`default_nettype wire

// ### dv/jfa_flash_model.sv
// Flash array model answering control block requests
`timescale 1ns/1ps
`default_nettype none
module jfa_flash_model
  import jfa_pkg::*;
#(
  parameter int LAT = 3
) (
  input  wire logic     clk,
  input  wire jfa_req_s req,
  input  wire logic     fail_in,
  output jfa_rsp_s      rsp
);
  logic [7:0] mem [512];
  jfa_req_s   held;
  int         cnt = 0;
  initial foreach (mem[i]) mem[i] = 8'hff;
  initial rsp = '0;
  always @(posedge clk) begin
    // Idle data wanders so it is never mistaken for a result
    rsp <= {2'b00, ~rsp.data};
    cnt <= req.valid ? LAT : (cnt > 0 ? cnt - 1 : 0);
    if (req.valid) held <= req;
    if (cnt == 1) begin
      rsp <= {1'b1, fail_in, mem[{held.scratch, held.addr[7:0]}]};
      if (held.op == JFA_OP_PROG && !fail_in) mem[{held.scratch, held.addr[7:0]}] <= held.data;
      if (held.op[1]) foreach (mem[i]) mem[i] <= 8'hff;
    end
  end
endmodule
`default_nettype wire

// ### dv/jfa_ctrl_sva.sv
// Port assertions for the flash access control block
`timescale 1ns/1ps
`default_nettype none
module jfa_ctrl_sva
  import jfa_pkg::*;
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic [7:0] ctrl_rdata,
  input wire logic [15:0] ptr_rdata,
  input wire logic       win_wr,
  input wire logic [7:0] win_wdata,
  input wire logic       win_rd,
  input wire logic [9:0] win_rdata,
  input wire jfa_req_s   flash_req,
  input wire jfa_rsp_s   flash_rsp
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  jfa_op_e last_op;
  always_ff @(posedge clk) if (flash_req.valid) last_op <= flash_req.op;
  chk_reset_clear: assert property (disable iff (1'b0) !nrst ##1 !nrst |=> ctrl_rdata == CTRL_RESET &&
    ptr_rdata == PTR_RESET && win_rdata == WIN_RESET && !flash_req.valid) else $error("reset values wrong");
  chk_ctrl_back: assert property (ctrl_wr |-> ##2 ctrl_rdata == $past(ctrl_wdata, 2))
    else $error("control read-back wrong");
  chk_store_only: assert property (win_wr && ctrl_rdata[6:4] == WR_STORE |=> !flash_req.valid)
    else $error("store mode launched");
  chk_prog_launch: assert property (win_wr && ctrl_rdata[6:4] == WR_PROGRAM && !win_rdata[0] && !flash_req.valid |=>
    flash_req.valid && flash_req.op == JFA_OP_PROG && flash_req.data == $past(win_wdata) &&
    flash_req.scratch == ctrl_rdata[7]) else $error("program request wrong");
  chk_erase_key: assert property (win_wr && ctrl_rdata[6:4] == WR_ERASE && !win_rdata[0] && !flash_req.valid |=>
    flash_req.valid == ($past(win_wdata) == ERASE_KEY)) else $error("erase key ignored");
  chk_block_read: assert property (win_rd && ctrl_rdata[3:0] == RD_BLOCK && !win_rdata[0] && !flash_req.valid |=>
    flash_req.valid && flash_req.op == JFA_OP_READ) else $error("block read not launched");
  chk_plain_read: assert property (win_rd && ctrl_rdata[3:0] == RD_PLAIN |=> !flash_req.valid)
    else $error("plain read launched");
  chk_busy_hold: assert property (flash_req.valid |=> win_rdata[0] && !flash_req.valid ##1 (!flash_req.valid) [*3])
    else $error("request while busy");
  chk_ptr_step: assert property (flash_rsp.done && !last_op[1] |-> ##2 ptr_rdata == $past(ptr_rdata, 2) + 16'h1)
    else $error("pointer not stepped");
  chk_read_data: assert property (flash_rsp.done && last_op == JFA_OP_READ |-> ##2
    win_rdata[9:2] == $past(flash_rsp.data, 2)) else $error("read byte not shown");
  cover property (flash_req.valid && flash_req.op == JFA_OP_USER_ERASE);
  cover property (flash_rsp.done && flash_rsp.fail);
  cover property (win_wr && win_rdata[0]);
endmodule
bind jfa_ctrl jfa_ctrl_sva u_sva (.*);
`default_nettype wire

// ### dv/jfa_ctrl_tb.sv
// Self-checking testbench for the flash access control block
`timescale 1ns/1ps
`default_nettype none
module jfa_ctrl_tb;
  import jfa_pkg::*;
  logic        clk = 0, nrst = 0, ctrl_wr = 0, ptr_wr = 0, win_wr = 0, win_rd = 0, fail_in = 0;
  logic [7:0]  ctrl_wdata = '0, win_wdata = '0, ctrl_rdata;
  logic [15:0] ptr_wdata = '0, ptr_rdata, reqs = '0, lock_rd_addr = 16'h0100, lock_wr_addr = 16'h0101;
  logic [9:0]  win_rdata;
  jfa_req_s    flash_req;
  jfa_rsp_s    flash_rsp;
  jfa_op_e     op_seen;
  int          num_errors = 0, checked = 0;
  jfa_ctrl DUT (.clk(clk), .nrst(nrst), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
    .ptr_wr(ptr_wr), .ptr_wdata(ptr_wdata), .ptr_rdata(ptr_rdata), .win_wr(win_wr), .win_wdata(win_wdata),
    .win_rd(win_rd), .win_rdata(win_rdata), .lock_rd_addr(lock_rd_addr), .lock_wr_addr(lock_wr_addr),
    .flash_req(flash_req), .flash_rsp(flash_rsp));
  jfa_flash_model FM (.clk(clk), .req(flash_req), .fail_in(fail_in), .rsp(flash_rsp));
  initial forever #20 clk = ~clk;
  always @(posedge clk) if (flash_req.valid) begin reqs <= reqs + 16'h1; op_seen <= flash_req.op; end
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin num_errors++; $display("unexpected %s exp %h got %h", name, exp, got); end
  endtask
  // One strobe: 0 control, 1 pointer, 2 window write, 3 window read
  task automatic put(int k, logic [15:0] v);
    @(posedge clk);
    {ctrl_wr, ptr_wr, win_wr, win_rd} <= {k == 0, k == 1, k == 2, k == 3};
    {ctrl_wdata, ptr_wdata, win_wdata} <= {v[7:0], v, v[7:0]};
    @(posedge clk);
    {ctrl_wr, ptr_wr, win_wr, win_rd} <= '0;
    @(negedge clk);
  endtask
  task automatic idle;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 50 && win_rdata[0] !== 1'b0; i++) @(negedge clk);
  endtask
  task automatic t_prog_read;
    put(0, 16'h0010); put(1, 16'h0005); put(2, 16'h003c); idle;
    chk("ptr", 16'h0006, ptr_rdata);
    put(0, 16'h0001); put(1, 16'h0005); put(2, 0); put(3, 0); idle;
    chk("data", 16'h003c, win_rdata[9:2]);
    put(3, 0);
    chk("data", 16'h003c, win_rdata[9:2]);
    idle;
    chk("ptr", 16'h0007, ptr_rdata);
    put(0, 0); put(3, 0); idle;
    chk("ptr", 16'h0007, ptr_rdata);
  endtask
  task automatic t_erase;
    logic [15:0] n;
    put(0, 16'h0020); put(1, 16'h0005); n = reqs; put(2, 16'h0012); idle;
    chk("win", 16'h0048, win_rdata);
    chk("reqs", n, reqs);
    put(2, 16'h00a5); idle;
    chk("op", JFA_OP_PAGE_ERASE, op_seen);
    chk("ptr", 16'h0005, ptr_rdata);
    put(1, lock_rd_addr); put(2, 16'h00a5); idle;
    chk("op", JFA_OP_USER_ERASE, op_seen);
    put(0, 0); n = reqs; put(2, 16'h00a5); idle;
    chk("reqs", n, reqs);
  endtask
  task automatic t_scratch;
    put(0, 16'h0090); put(1, 16'h0003); put(2, 16'h0077); idle;
    put(0, 16'h0081); put(1, 16'h0003); put(3, 0); idle;
    chk("data", 16'h0077, win_rdata[9:2]);
    put(0, 16'h0001); put(1, 16'h0003); put(3, 0); idle;
    chk("data", 16'h00ff, win_rdata[9:2]);
  endtask
  task automatic t_busy_fail;
    logic [15:0] n;
    n = reqs;
    @(posedge clk) fail_in <= 1'b1;
    put(0, 16'h0010); put(1, 16'h0009); put(2, 16'h0011); put(2, 16'h0022); idle;
    chk("win", 16'h0046, win_rdata);
    chk("ptr", 16'h000a, ptr_rdata);
    chk("reqs", n + 16'h1, reqs);
    @(posedge clk) fail_in <= 1'b0;
  endtask
  task automatic t_single;
    logic [15:0] n;
    put(0, 0); put(3, 0); put(0, 16'h0002); put(1, 16'h0020); n = reqs;
    put(3, 0); idle; put(3, 0); idle; put(3, 0); idle;
    chk("reqs", n + 16'h2, reqs);
    chk("ptr", 16'h0022, ptr_rdata);
  endtask
  task automatic results;
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Whole run needs well under 1000 cycles
  initial begin #100000; num_errors++; results; end
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk("ctrl", 16'h0000, ctrl_rdata);
    chk("win", 16'h0000, win_rdata);
    t_prog_read; t_erase; t_scratch; t_busy_fail; t_single;
    results;
  end
endmodule
`default_nettype wire
